// ===== design/rxc_pkg.sv
// rxc_pkg: constants and types of the receiver configuration block.
// assumes a single 50 MHz clock and frames on the shared data line.
package rxc_pkg;
  // frame shape; frame bit n lands at shift index FRM_LEN-n
  localparam int FRM_LEN = 15;
  localparam int IX_OFF  = 14;
  localparam int IX_SEL  = 13;
  localparam int IX_STOP = 0;
  // payload field positions, payload[11] is frame bit 3
  localparam int OP_BAUD_LSB  = 10;
  localparam int OP_CHK_LSB   = 8;
  localparam int OP_MOD_POS   = 7;
  localparam int OP_SLEEP_LSB = 2;
  localparam int OP_STR_POS   = 1;
  localparam int OP_NOISE_POS = 0;
  localparam int LIM_MAX_LSB  = 0;
  localparam int LIM_MIN_LSB  = 6;
  // power-on contents
  localparam logic [11:0] OP_RST  = 12'h0119;
  localparam logic [11:0] LIM_RST = 12'h0569;
  localparam logic [4:0] SLEEP_FOREVER = 5'h001f;
  localparam logic [3:0] STRETCH_X8    = 4'h0008;
  localparam int SLEEP_UNIT = 1024;
  // line timing
  localparam int CLK_MHZ    = 50;
  localparam int T_LONG_NS  = 20000;
  localparam int T_GAP_NS   = 50000;
  localparam int T_MARK_NS  = 10000;
  localparam int LONG_CYC   = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC    = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int MARK_CYC   = (T_MARK_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {MD_SLEEP, MD_STARTUP, MD_RECEIVE} rxc_mode_t;

  typedef struct packed {
    logic [1:0] baud_band_sel;
    logic [1:0] bitchk_sel;
    logic       modulation_sel;
    logic [4:0] sleep_value;
    logic       sleep_stretch;
    logic       noise_supp;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
  } rxc_cfg_t;
endpackage

// ===== design/rxc_top.sv
// rxc_top: frame interpreter, configuration store and mode control.
// assumes all inputs synchronous to i_clk; the data line is open drain.
`timescale 1ns/1ns

// Overview of operation
// - noise bit 0: demodulated noise keeps reaching data line after stream end
// - host holds polling/on low: device stays in receiving mode; off command and, with noise bit 1, stream end still go to start-up
// - polling/on low: off command goes to start-up, skipping sleep, bit check kept
// - successful bit check returns device to receiving mode
// - two 12-bit write-only registers, written only over the data line
// - supply drop: contents lost pattern emitted outside receiving mode; host reprograms
// - power-on reset loads defaults into both registers
// - frame bit 1 high is off command; low is register write
// - frame bit 2 selects operating config (1) or bounds (0)
// - write committed only when stop bit 15 is 0
// - operating config layout: baud, bit check, modulation, sleep, stretch, noise
// - operating config defaults 00, 01, 0, 00110, 0, 1
// - bounds layout: six-bit lower then upper limit, defaults 010101, 101001
// - baud band selects window multiplier 8, 4, 2 or 1
// - bit-check count field gives 0, 3, 6 or 9 bits
// - modulation select 0 is FSK, 1 is ASK
// - sleep stretch multiplies sleep time by 1 or 8
// - sleep time is value times stretch times 1024; 0 polls, 31 sleeps forever
// - noise bit 1: data line stays high after stream end
module rxc_top
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // shared data line
  input  wire logic             i_data,
  output logic                  o_data,
  output logic                  o_data_oe_n,
  // host control pin, low keeps the device out of sleep
  input  wire logic             i_polling_n,
  // receiver front end
  input  wire logic             i_demod,
  input  wire logic             i_bitchk_ok,
  input  wire logic             i_bitchk_fail,
  input  wire logic             i_stream_end,
  input  wire logic             i_supply_drop,
  // state seen by the front end
  output rxc_pkg::rxc_mode_t    o_mode,
  output rxc_pkg::rxc_cfg_t     o_cfg,
  output logic [3:0]            o_window_mult,
  output logic [3:0]            o_bitchk_num,
  output logic                  o_contents_lost
);

  function automatic logic [3:0] mult_of(input logic [1:0] band);
    // band 00 is the slowest range, so the widest window
    mult_of = 4'h0008 >> band;
  endfunction

  function automatic logic [3:0] chk_of(input logic [1:0] sel);
    chk_of = 4'(3 * int'(sel));
  endfunction

  localparam int CW = 16;

  logic [11:0]         op_q, op_d, lim_q, lim_d;
  rxc_pkg::rxc_mode_t  mode_q, mode_d;
  logic [14:0]         sh_q, sh_d;
  logic [3:0]          nbit_q, nbit_d;
  logic [CW-1:0]       low_q, low_d, high_q, high_d;
  logic                prev_q, prev_d;
  logic [9:0]          unit_q, unit_d;
  logic [7:0]          units_q, units_d;
  logic                lost_q, lost_d;
  logic [CW-1:0]       mark_q, mark_d;
  logic                pol_q, pol_d;
  logic                dat_d, oe_n_q, oe_n_d;
  logic [3:0]          mult_q, mult_d, chk_q, chk_d;
  logic                frame_done;
  logic                bitv;
  logic [14:0]         fr;
  logic [7:0]          sleep_len;

  localparam int OP_STR_POS_L = rxc_pkg::OP_STR_POS;
  localparam int OP_NOISE_L   = rxc_pkg::OP_NOISE_POS;

  always_comb
  begin
    op_d    = op_q;
    lim_d   = lim_q;
    mode_d  = mode_q;
    sh_d    = sh_q;
    nbit_d  = nbit_q;
    low_d   = low_q;
    high_d  = high_q;
    prev_d  = i_data;
    unit_d  = unit_q;
    units_d = units_q;
    lost_d  = lost_q;
    mark_d  = mark_q;
    pol_d   = i_polling_n;
    frame_done = 1'b0;
    bitv    = 1'b0;
    fr      = sh_q;
    // sleep length in units of 1024 clocks
    // stretch factor
    sleep_len = op_q[OP_STR_POS_L] ? {op_q[6:2], 3'b000} : {3'b000, op_q[6:2]};

    // host bits are only seen while this end releases the line
    if (oe_n_q)
    begin
      if (!i_data)
      begin
        if (low_q != '1)
          low_d = low_q + CW'(1);
        high_d = '0;
      end
      else
      begin
        low_d = '0;
        if (high_q != '1)
          high_d = high_q + CW'(1);
        if (high_q == CW'(rxc_pkg::GAP_CYC))
          nbit_d = '0;
      end
      if (!prev_q && i_data && low_q != '0)
      begin
        bitv = (low_q >= CW'(rxc_pkg::LONG_CYC));
        fr   = {sh_q[13:0], bitv};
        sh_d = fr;
        if (nbit_q == 4'(rxc_pkg::FRM_LEN - 1))
        begin
          frame_done = 1'b1;
          nbit_d = '0;
        end
        else
          nbit_d = nbit_q + 4'h0001;
      end
    end
    else
    begin
      low_d  = '0;
      high_d = '0;
    end

    unit_d = unit_q + 10'h0001;

    case (mode_q)
      rxc_pkg::MD_SLEEP:
      begin
        if (unit_q == 10'(rxc_pkg::SLEEP_UNIT - 1) && units_q != '0)
          units_d = units_q - 8'h0001;
        // low pin skips the sleep time
        if (!i_polling_n)
          mode_d = rxc_pkg::MD_STARTUP;
        // value 31 waits for the pin only
        else if (op_q[6:2] != rxc_pkg::SLEEP_FOREVER && units_q == '0)
          mode_d = rxc_pkg::MD_STARTUP;
      end
      rxc_pkg::MD_STARTUP:
      begin
        // back to receiving after a good bit check
        if (i_bitchk_ok)
          mode_d = rxc_pkg::MD_RECEIVE;
        else if (i_bitchk_fail && i_polling_n)
        begin
          mode_d  = rxc_pkg::MD_SLEEP;
          units_d = sleep_len;
          unit_d  = '0;
        end
      end
      rxc_pkg::MD_RECEIVE:
      begin
        // automatic suppression falls back to bit check
        if (i_stream_end && op_q[OP_NOISE_L])
          mode_d = rxc_pkg::MD_STARTUP;
        // a rising pin leaves receiving for polling, as does an off command with the pin high
        else if (i_polling_n && !pol_q)
        begin
          mode_d  = rxc_pkg::MD_SLEEP;
          units_d = sleep_len;
          unit_d  = '0;
        end
      end
      default:
        mode_d = rxc_pkg::MD_SLEEP;
    endcase

    if (frame_done)
    begin
      // off command ignores the other bits
      if (fr[rxc_pkg::IX_OFF])
      begin
        // pin low: start-up with bit check, no sleep
        if (!i_polling_n)
          mode_d = rxc_pkg::MD_STARTUP;
        else
        begin
          mode_d  = rxc_pkg::MD_SLEEP;
          units_d = sleep_len;
          unit_d  = '0;
        end
      end
      else if (!fr[rxc_pkg::IX_STOP])
      begin
        if (fr[rxc_pkg::IX_SEL])
          op_d = fr[12:1];
        else
          lim_d = fr[12:1];
        lost_d = 1'b0;
      end
    end

    if (mark_q != '0)
      mark_d = mark_q - CW'(1);

    // lost contents: defaults back, pattern out unless receiving
    if (i_supply_drop)
    begin
      op_d   = rxc_pkg::OP_RST;
      lim_d  = rxc_pkg::LIM_RST;
      lost_d = 1'b1;
      mark_d = CW'(rxc_pkg::MARK_CYC);
    end

    // receiving drives the stream, noise included when unsuppressed
    if (mode_q == rxc_pkg::MD_RECEIVE)
      dat_d = i_demod;
    else
      dat_d = (mark_q == '0);
    oe_n_d = dat_d;

    // decoded figures for the bit checker
    mult_d = mult_of(op_q[11:10]);
    chk_d  = chk_of(op_q[9:8]);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      op_q    <= rxc_pkg::OP_RST;
      lim_q   <= rxc_pkg::LIM_RST;
      mode_q  <= rxc_pkg::MD_STARTUP;
      sh_q    <= '0;
      nbit_q  <= '0;
      low_q   <= '0;
      high_q  <= '0;
      prev_q  <= 1'b1;
      unit_q  <= '0;
      units_q <= '0;
      lost_q  <= 1'b0;
      mark_q  <= '0;
      pol_q   <= 1'b1;
      oe_n_q  <= 1'b1;
      mult_q  <= 4'h0008;
      chk_q   <= 4'h0003;
    end
    else
    begin
      op_q    <= op_d;
      lim_q   <= lim_d;
      mode_q  <= mode_d;
      sh_q    <= sh_d;
      nbit_q  <= nbit_d;
      low_q   <= low_d;
      high_q  <= high_d;
      prev_q  <= prev_d;
      unit_q  <= unit_d;
      units_q <= units_d;
      lost_q  <= lost_d;
      mark_q  <= mark_d;
      pol_q   <= pol_d;
      oe_n_q  <= oe_n_d;
      mult_q  <= mult_d;
      chk_q   <= chk_d;
    end
  end

  // registers leave only as configuration, never read back; modulation_sel rides along
  assign o_cfg           = {op_q, lim_q};
  assign o_mode          = mode_q;
  assign o_data          = 1'b0;
  assign o_data_oe_n     = oe_n_q;
  assign o_window_mult   = mult_q;
  assign o_bitchk_num    = chk_q;
  assign o_contents_lost = lost_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  AST_OFF_LOW_PIN: assert property (frame_done && fr[14] && !i_polling_n
    |=> mode_q == rxc_pkg::MD_STARTUP) else $error("off with pin low not start-up");
  AST_BITCHK_OK: assert property (mode_q == rxc_pkg::MD_STARTUP && i_bitchk_ok
    && !frame_done |=> mode_q == rxc_pkg::MD_RECEIVE) else $error("no receive after check");
  AST_HOLD_RX: assert property (mode_q == rxc_pkg::MD_RECEIVE && !i_polling_n
    && !frame_done && !(i_stream_end && op_q[0]) |=> mode_q == rxc_pkg::MD_RECEIVE)
    else $error("left receive with pin low");
  AST_NOISE_PASS: assert property (mode_q == rxc_pkg::MD_RECEIVE && !op_q[0]
    && !i_demod |=> !oe_n_q) else $error("noise not passed");
  AST_NOISE_SUPP: assert property (mode_q == rxc_pkg::MD_RECEIVE && op_q[0]
    && i_stream_end && !frame_done |=> mode_q == rxc_pkg::MD_STARTUP
    ##1 (oe_n_q || $past(mark_q) != '0))
    else $error("noise not suppressed");
  AST_STOP_BIT: assert property (frame_done && !fr[14] && fr[0] && !i_supply_drop
    |=> $stable(op_q) && $stable(lim_q)) else $error("write with stop bit 1");
  AST_WRITE_OP: assert property (frame_done && fr[14:13] == 2'b01 && !fr[0]
    && !i_supply_drop |=> op_q == $past(fr[12:1])) else $error("operating write lost");
  AST_DROP: assert property (i_supply_drop |=> op_q == rxc_pkg::OP_RST
    && lim_q == rxc_pkg::LIM_RST && lost_q
    ##1 (!oe_n_q || $past(mode_q) == rxc_pkg::MD_RECEIVE))
    else $error("no lost pattern");
  AST_MULT: assert property (##1 $stable(op_q) |=> o_window_mult
    == (4'h0008 >> $past(op_q[11:10], 2))) else $error("bad multiplier");
  AST_CHK: assert property (##1 $stable(op_q) |=> o_bitchk_num
    == (($past(op_q[9:8], 2) == 2'b00) ? 4'h0000 : ($past(op_q[9:8], 2) == 2'b01) ? 4'h0003
    : ($past(op_q[9:8], 2) == 2'b10) ? 4'h0006 : 4'h0009)) else $error("bad bit count");

  COV_OFF: cover property (frame_done && fr[14]);
  COV_WRITE: cover property (frame_done && !fr[14] && !fr[0]);
  COV_RX: cover property (mode_q == rxc_pkg::MD_STARTUP ##1 mode_q == rxc_pkg::MD_RECEIVE);
  COV_POLL: cover property (mode_q == rxc_pkg::MD_RECEIVE ##1 mode_q == rxc_pkg::MD_SLEEP);

endmodule // rxc_top

// ===== sim/rxc_host_model.sv
// rxc_host_model: host controller on the shared data line and the polling pin.
// assumes a pull-up on the line; the bench resolves the wired level.
`timescale 1ns/1ns
module rxc_host_model
(
  // clock
  input  wire logic i_clk,
  // resolved line level
  input  wire logic i_line,
  // pull-down enable, low pulls the line
  output logic      o_drive_n,
  // polling/on pin
  output logic      o_polling_n
);
  initial
  begin
    o_drive_n   = 1'b1;
    o_polling_n = 1'b1;
  end

  // a long low is a one; the device may still hold its marker, so wait it out
  task automatic send_bit(input logic b);
    int n;
    n = 0;
    while (i_line !== 1'b1 && n < 5000)
    begin
      @(posedge i_clk);
      n++;
    end
    o_drive_n <= 1'b0;
    repeat (b ? rxc_pkg::LONG_CYC + 20 : 20) @(posedge i_clk);
    o_drive_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask

  task automatic send_frame(input logic off, input logic sel, input logic [11:0] pay,
                            input logic stop);
    logic [14:0] f;
    f = {off, sel, pay, stop};
    for (int i = 14; i >= 0; i--) send_bit(f[i]);
  endtask

  // low keeps the device out of sleep, high resumes polling
  task automatic set_pin(input logic v);
    o_polling_n <= v;
    @(posedge i_clk);
  endtask
endmodule // rxc_host_model

// ===== sim/rxc_top_tb_top.sv
// rxc_top_tb_top: frames, mode control and supply-drop recovery of rxc_top.
// assumes the host model and design meet on a pulled-up open-drain line.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module rxc_top_tb_top;
  logic               i_clk;
  logic               i_srst;
  logic               i_demod;
  logic [3:0]         ev;
  logic               o_data;
  logic               o_data_oe_n;
  logic               o_contents_lost;
  logic               host_drive_n;
  logic               polling_n;
  logic               line;
  logic [11:0]        pay;
  rxc_pkg::rxc_mode_t o_mode;
  rxc_pkg::rxc_cfg_t  o_cfg;
  logic [3:0]         o_window_mult;
  logic [3:0]         o_bitchk_num;
  int                 bad_count;
  int                 samples_checked;

  assign line = host_drive_n & (o_data_oe_n | o_data);

  rxc_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_data(line), .o_data(o_data),
    .o_data_oe_n(o_data_oe_n), .i_polling_n(polling_n), .i_demod(i_demod),
    .i_bitchk_ok(ev[3]), .i_bitchk_fail(ev[2]), .i_stream_end(ev[1]),
    .i_supply_drop(ev[0]), .o_mode(o_mode), .o_cfg(o_cfg),
    .o_window_mult(o_window_mult), .o_bitchk_num(o_bitchk_num),
    .o_contents_lost(o_contents_lost));

  rxc_host_model HOST (.i_clk(i_clk), .i_line(line), .o_drive_n(host_drive_n),
    .o_polling_n(polling_n));

  always #10 i_clk = ~i_clk;

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one-cycle event pulse, then sample once the registered mode has settled
  task automatic pulse(input logic [3:0] m);
    @(posedge i_clk);
    ev <= m;
    @(posedge i_clk);
    ev <= 4'h0;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic frame(input logic off, input logic sel, input logic [11:0] p,
                       input logic stop);
    @(posedge i_clk);
    HOST.send_frame(off, sel, p, stop);
    @(negedge i_clk);
  endtask

  task automatic pin(input logic v);
    @(posedge i_clk);
    HOST.set_pin(v);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  initial
  begin
    i_clk = 1'b0;
    i_srst = 1'b1;
    i_demod = 1'b1;
    ev = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("cfg", {12'h0119, 12'h0569}, o_cfg)
    `CHK("mult", 4'h8, o_window_mult)
    `CHK("chk", 4'h3, o_bitchk_num)
    `CHK("lost", 1'b0, o_contents_lost)
    for (int i = 0; i < 4; i++)
    begin
      pay = {i[1:0], i[1:0], 1'b1, (i == 3) ? 5'h1f : 5'h00, 2'b00};
      frame(1'b0, 1'b1, pay, 1'b0);
      @(negedge i_clk);
      `CHK("op", pay, o_cfg[23:12])
      `CHK("mult", 4'h8 >> i, o_window_mult)
      `CHK("chk", 4'(3 * i), o_bitchk_num)
    end
    `CHK("ask", 1'b1, o_cfg.modulation_sel)
    `CHK("sleep", 5'h1f, o_cfg.sleep_value)
    frame(1'b0, 1'b0, 12'h0a5c, 1'b1);
    `CHK("lim", 12'h0569, o_cfg[11:0])
    frame(1'b0, 1'b0, 12'h0a5c, 1'b0);
    `CHK("lim", 12'h0a5c, o_cfg[11:0])
    `CHK("min", 6'h29, o_cfg.lim_min)
    pin(1'b0);
    pulse(4'h4);
    `CHK("mode", rxc_pkg::MD_STARTUP, o_mode)
    pulse(4'h8);
    `CHK("mode", rxc_pkg::MD_RECEIVE, o_mode)
    pulse(4'h2);
    `CHK("mode", rxc_pkg::MD_RECEIVE, o_mode)
    // noise bit 0: a low demodulated level must reach the line
    @(posedge i_clk);
    i_demod <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("noise", 1'b0, o_data_oe_n)
    @(posedge i_clk);
    i_demod <= 1'b1;
    frame(1'b1, 1'b0, 12'h0000, 1'b0);
    `CHK("mode", rxc_pkg::MD_STARTUP, o_mode)
    pulse(4'h8);
    `CHK("mode", rxc_pkg::MD_RECEIVE, o_mode)
    pin(1'b1);
    `CHK("mode", rxc_pkg::MD_SLEEP, o_mode)
    pulse(4'h1);
    `CHK("cfg", {12'h0119, 12'h0569}, o_cfg)
    `CHK("lost", 1'b1, o_contents_lost)
    `CHK("mark", 1'b0, o_data_oe_n)
    pin(1'b0);
    pulse(4'h8);
    pulse(4'h2);
    `CHK("mode", rxc_pkg::MD_STARTUP, o_mode)
    // sleep value 1 with stretch: eight units of 1024 clocks
    frame(1'b0, 1'b1, 12'h0107, 1'b0);
    `CHK("lost", 1'b0, o_contents_lost)
    `CHK("stretch", 1'b1, o_cfg.sleep_stretch)
    pin(1'b1);
    pulse(4'h4);
    `CHK("mode", rxc_pkg::MD_SLEEP, o_mode)
    repeat (7000) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("mode", rxc_pkg::MD_SLEEP, o_mode)
    repeat (1200) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("mode", rxc_pkg::MD_STARTUP, o_mode)
    wrap_up();
  end

  initial
  begin
    repeat (95000) @(posedge i_clk);
    bad_count++;
    wrap_up();
  end
endmodule // rxc_top_tb_top
